// *** core/touch_pkg.sv ***
// Purpose: Shared constants for slider position and key suppression
// Assumes: 16 keys, keys 0..7 on receive line zero, drive line n = key n
// Notes:   Register offsets are byte addresses on a 32-bit APB
package touch_pkg;
  localparam int           NUM_KEYS      = 16;
  localparam int           DELTA_W       = 12;
  localparam int           OBJ_W         = 5;
  localparam logic [4:0]   SLIDER_OBJ    = 5'h10;   // Object id of the slider
  localparam logic [4:0]   NO_OBJ        = 5'h1F;
  // Register byte offsets
  localparam logic [7:0]   OFS_CTRL      = 8'h00;
  localparam logic [7:0]   OFS_GROUP     = 8'h04;
  localparam logic [7:0]   OFS_STATUS    = 8'h08;
  localparam logic [7:0]   OFS_POSITION  = 8'h0C;
  localparam logic [7:0]   OFS_RAW       = 8'h10;
  // Control and status field positions
  localparam int           CTRL_LEN_LSB  = 0;
  localparam int           CTRL_RES_LSB  = 4;
  localparam int           CTRL_LIM_LSB  = 8;
  localparam int           STAT_SLD_BIT  = 16;
  // Reset values and setting limits
  localparam logic [3:0]   LEN_RST       = 4'h0;   // No slider
  localparam logic [3:0]   RES_RST       = 4'h8;
  localparam logic [7:0]   LIM_RST       = 8'h0A;
  localparam logic [31:0]  GROUP_RST     = 32'h0000_0000;
  localparam logic [3:0]   RES_MIN       = 4'h2;
  localparam logic [3:0]   RES_MAX       = 4'h8;
  localparam logic [3:0]   LEN_MIN       = 4'h2;
  localparam logic [3:0]   LEN_MAX       = 4'h8;

  // Largest position code for a resolution, clamped to 2..8 bits
  function automatic logic [7:0] max_code(input logic [3:0] res);
    logic [3:0] r;
    r = (res < RES_MIN) ? RES_MIN : ((res > RES_MAX) ? RES_MAX : res);
    return 8'((9'h001 << r) - 9'h001);
  endfunction

  // Suppression group of one key from the packed group register
  function automatic logic [1:0] group_of(input logic [31:0] cfg, input int k);
    return cfg[2*k +: 2];
  endfunction

  // Slider length in keys, zero when the setting is out of range
  function automatic logic [3:0] slider_keys(input logic [3:0] len);
    return (len >= LEN_MIN && len <= LEN_MAX) ? len : 4'h0;
  endfunction
endpackage

// *** core/slider_position.sv ***
// Purpose: Centroid finger position across the slider keys
// Assumes: Deltas are unsigned; only detecting slider keys contribute
// Notes:   Combinational; the caller registers the result
`timescale 1ns/1ps
module slider_position (
  input  wire logic [11:0] delta    [16],
  input  wire logic [15:0] detect,
  input  wire logic [3:0]  len,
  input  wire logic [3:0]  res,
  output logic             valid,
  output logic [7:0]       position
);
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] quo;
  logic [7:0]  top;

  // Weighted sum, then scale key span onto the code range
  always_comb begin
    num = 32'h0000_0000;
    den = 32'h0000_0000;
    for (int k = 0; k < 8; k++) begin
      if (k < int'(len) && detect[k]) begin
        num = num + 32'(delta[k]) * 32'(k);
        den = den + 32'(delta[k]);
      end
    end
    top   = touch_pkg::max_code(res);
    valid = (den != 32'h0000_0000);
    // Division kept at full width; a scan is long, so timing is relaxed
    quo   = (valid && len > 4'h1) ?
            (num * 32'(top)) / (den * 32'(len - 4'h1)) : 32'h0000_0000;
    position = (quo > 32'(top)) ? top : quo[7:0]; // R15
  end
endmodule // slider_position

// *** core/touch_status.sv ***
// Purpose: Detect integration, slider object, grouped suppression, APB regs
// Assumes: One acquisition result per acq_valid pulse; scan_done ends a scan
// Notes:   Status and position change only at scan_done
//
// Behaviour
// R1: The slider is built from receive-line-zero keys starting at drive line zero, in order.
// R2: Slider length is programmable and remaining keys on that line act as plain keys.
// R3: Position resolution is programmable from 2 bits (0..3) to 8 bits (0..255).
// R4: The slider is a single object in suppression grouping.
// R5: Up to three groups exist and each reports at most one touched object.
// R6: A dominant object stays locked and blocks its group until released.
// R7: Group setting 1..3 selects a group and 0 exempts the key from suppression.
// R8: Slider keys never suppress one another and may detect together.
// R9: Slider and keys in one group suppress each other, first touch winning.
// R10: Software should put all slider keys into one common group.
// R11: Software should give slider keys equal burst length and threshold.
// R12: A key detects once its above-threshold counter reaches the limit; below clears it.
// R13: The active-low change line asserts whenever reported status changes.
// R14: With no lock, the detecting member with the largest delta becomes dominant.
// R15: Position is unsigned, scaled over the slider and saturates at the top code.
`timescale 1ns/1ps
module touch_status (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        acq_valid,
  input  wire logic [3:0]  acq_key,
  input  wire logic        acq_above,
  input  wire logic [11:0] acq_delta,
  input  wire logic        scan_done,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             change_n,
  output logic             change_oe
);
  // Configuration and APB state
  logic [3:0]  len_r, len_nxt;
  logic [3:0]  res_r, res_nxt;
  logic [7:0]  lim_r, lim_nxt;
  logic [31:0] grp_r, grp_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        apb_done;
  logic        rd_status;
  // Reported state, declared early for the read mux
  logic [15:0] detect_r;
  logic [15:0] status_r;
  logic        slider_rep_r;
  logic [7:0]  pos_r;

  assign apb_done = psel && penable && pready_r;

  // One wait state so read data comes straight from a flop
  always_comb begin
    len_nxt     = len_r;
    res_nxt     = res_r;
    lim_nxt     = lim_r;
    grp_nxt     = grp_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt  = psel && penable && !pready_r;
    rd_status   = apb_done && !pwrite && paddr == touch_pkg::OFS_STATUS;
    if (psel && penable && !pready_r) begin
      prdata_nxt = 32'h0000_0000;
      if (paddr == touch_pkg::OFS_CTRL) begin
        prdata_nxt = {16'h0000, lim_r, res_r, len_r};
      end else if (paddr == touch_pkg::OFS_GROUP) begin
        prdata_nxt = grp_r;
      end else if (paddr == touch_pkg::OFS_STATUS) begin
        prdata_nxt = {15'h0000, slider_rep_r, status_r};
      end else if (paddr == touch_pkg::OFS_POSITION) begin
        prdata_nxt = {24'h000000, pos_r};
      end else if (paddr == touch_pkg::OFS_RAW) begin
        prdata_nxt = {16'h0000, detect_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    if (apb_done && pwrite) begin
      if (paddr == touch_pkg::OFS_CTRL) begin
        len_nxt = pwdata[touch_pkg::CTRL_LEN_LSB +: 4]; // R2
        res_nxt = pwdata[touch_pkg::CTRL_RES_LSB +: 4]; // R3
        lim_nxt = pwdata[touch_pkg::CTRL_LIM_LSB +: 8];
      end else if (paddr == touch_pkg::OFS_GROUP) begin
        grp_nxt = pwdata; // R7
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      len_r     <= touch_pkg::LEN_RST;
      res_r     <= touch_pkg::RES_RST;
      lim_r     <= touch_pkg::LIM_RST;
      grp_r     <= touch_pkg::GROUP_RST;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      len_r     <= len_nxt;
      res_r     <= res_nxt;
      lim_r     <= lim_nxt;
      grp_r     <= grp_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;    // Only ever set alongside pready

  // Detection integrator state per key
  logic [7:0]  cnt_r    [16];
  logic [7:0]  cnt_nxt  [16];
  logic [11:0] delta_r  [16];
  logic [11:0] delta_nxt[16];
  logic [15:0] detect_nxt;
  logic [7:0]  lim_eff;

  // Limit of zero treated as one so a key can still detect
  always_comb begin
    lim_eff    = (lim_r == 8'h00) ? 8'h01 : lim_r;
    cnt_nxt    = cnt_r;
    delta_nxt  = delta_r;
    detect_nxt = detect_r;
    if (acq_valid) begin
      delta_nxt[acq_key] = acq_delta;
      if (acq_above) begin
        if (cnt_r[acq_key] < lim_eff) begin
          cnt_nxt[acq_key] = cnt_r[acq_key] + 8'h01; // R12
        end
        // Nine bits so a limit of 255 cannot wrap the compare
        detect_nxt[acq_key] = ({1'b0, cnt_r[acq_key]} + 9'h001) >= {1'b0, lim_eff}; // R12
      end else begin
        cnt_nxt[acq_key]    = 8'h00; // R12
        detect_nxt[acq_key] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < 16; k++) begin
        cnt_r[k]   <= 8'h00;
        delta_r[k] <= 12'h000;
      end
      detect_r <= 16'h0000;
    end else begin
      cnt_r    <= cnt_nxt;
      delta_r  <= delta_nxt;
      detect_r <= detect_nxt;
    end
  end

  // Object view and group arbitration
  logic [3:0]  slen;
  logic [16:0] obj_det;
  logic [11:0] obj_delta [17];
  logic [1:0]  obj_grp   [17];
  logic [16:0] obj_win;
  logic [15:0] status_nxt;
  logic        slider_rep_nxt;
  logic        lock_v_r  [1:3];
  logic        lock_v_nxt[1:3];
  logic [4:0]  lock_id_r  [1:3];
  logic [4:0]  lock_id_nxt[1:3];
  logic        keep      [1:3];
  logic [11:0] best;
  logic [4:0]  best_id;

  always_comb begin
    slen = touch_pkg::slider_keys(len_r);
    for (int k = 0; k < 16; k++) begin
      // Slider keys leave the plain-key pool; the rest stay keys
      obj_det[k]   = detect_r[k] && !(k < int'(slen)); // R1 R2
      obj_delta[k] = delta_r[k];
      obj_grp[k]   = touch_pkg::group_of(grp_r, k);
    end
    obj_det[16]   = 1'b0;
    obj_delta[16] = 12'h000;
    obj_grp[16]   = touch_pkg::group_of(grp_r, 0); // Group of first slider key
    for (int k = 0; k < 8; k++) begin
      if (k < int'(slen) && detect_r[k]) begin
        obj_det[16] = 1'b1; // R4
        if (delta_r[k] > obj_delta[16]) begin
          obj_delta[16] = delta_r[k];
        end
      end
    end
    obj_win = 17'h00000;
    for (int g = 1; g <= 3; g++) begin
      keep[g]        = lock_v_r[g] && obj_det[lock_id_r[g]] &&
                       obj_grp[lock_id_r[g]] == 2'(g);
      lock_v_nxt[g]  = lock_v_r[g];
      lock_id_nxt[g] = lock_id_r[g];
      best    = 12'h000;
      best_id = touch_pkg::NO_OBJ;
      for (int o = 0; o < 17; o++) begin
        if (obj_det[o] && obj_grp[o] == 2'(g) &&
            (best_id == touch_pkg::NO_OBJ || obj_delta[o] > best)) begin
          best    = obj_delta[o]; // R14
          best_id = 5'(o);
        end
      end
      if (scan_done) begin
        if (keep[g]) begin
          lock_id_nxt[g] = lock_id_r[g]; // R6 R9
        end else begin
          lock_v_nxt[g]  = best_id != touch_pkg::NO_OBJ;
          lock_id_nxt[g] = best_id;
        end
      end
      if (lock_v_nxt[g] && lock_id_nxt[g] != touch_pkg::NO_OBJ) begin
        obj_win[lock_id_nxt[g]] = 1'b1; // R5
      end
    end
    slider_rep_nxt = obj_det[16] && (obj_grp[16] == 2'h0 || obj_win[16]);
    for (int k = 0; k < 16; k++) begin
      if (k < int'(slen)) begin
        // No suppression among slider keys themselves
        status_nxt[k] = detect_r[k] && slider_rep_nxt; // R8
      end else begin
        status_nxt[k] = obj_det[k] && (obj_grp[k] == 2'h0 || obj_win[k]); // R7
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int g = 1; g <= 3; g++) begin
        lock_v_r[g]  <= 1'b0;
        lock_id_r[g] <= touch_pkg::NO_OBJ;
      end
    end else begin
      lock_v_r  <= lock_v_nxt;
      lock_id_r <= lock_id_nxt;
    end
  end

  // Reported status, position and change line
  logic [15:0] status_upd;
  logic        slider_upd;
  logic [7:0]  pos_upd;
  logic        change_r, change_upd;
  logic        change_n_r, change_n_upd;
  logic        pos_v;
  logic [7:0]  pos_calc;
  logic        diff;

  slider_position u_pos (
    .delta    (delta_r),
    .detect   (detect_r),
    .len      (slen),
    .res      (res_r),
    .valid    (pos_v),
    .position (pos_calc)
  );

  // Set beats the clearing read in the same cycle
  always_comb begin
    status_upd = status_r;
    slider_upd = slider_rep_r;
    pos_upd    = pos_r;
    diff       = scan_done && (status_nxt != status_r ||
                               slider_rep_nxt != slider_rep_r);
    if (scan_done) begin
      status_upd = status_nxt;
      slider_upd = slider_rep_nxt;
      if (pos_v && slider_rep_nxt) begin
        pos_upd = pos_calc; // R3 R15
      end
    end
    change_upd = diff ? 1'b1 : (rd_status ? 1'b0 : change_r); // R13
    change_n_upd = !change_upd;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_r     <= 16'h0000;
      slider_rep_r <= 1'b0;
      pos_r        <= 8'h00;
      change_r     <= 1'b0;
      change_n_r   <= 1'b1;
    end else begin
      status_r     <= status_upd;
      slider_rep_r <= slider_upd;
      pos_r        <= pos_upd;
      change_r     <= change_upd;
      change_n_r   <= change_n_upd;
    end
  end

  // Open-drain line: driven low only while a change is pending
  assign change_n  = change_n_r;
  assign change_oe = change_r;

  // Checks
  logic [1:0] grp_hits [1:3];
  logic       multi;
  always_comb begin
    multi = 1'b0;
    for (int g = 1; g <= 3; g++) begin
      grp_hits[g] = 2'h0;
      for (int k = 0; k < 16; k++) begin
        if (status_r[k] && !(k < int'(slen)) && obj_grp[k] == 2'(g) &&
            grp_hits[g] != 2'h3) begin
          grp_hits[g] = grp_hits[g] + 2'h1;
        end
      end
      if (grp_hits[g] > 2'h1 || (grp_hits[g] != 2'h0 && slider_rep_r &&
                                 obj_grp[16] == 2'(g))) begin
        multi = 1'b1;
      end
    end
  end

  property p_integ_clear;
    @(posedge ref_clk) disable iff (reset)
      acq_valid && !acq_above |=> !detect_r[$past(acq_key)] && cnt_r[$past(acq_key)] == 8'h00;
  endproperty
  a_integ_clear: assert property (p_integ_clear) else $error("key detect not cleared"); // R12

  property p_change_set;
    @(posedge ref_clk) disable iff (reset) diff |=> !change_n && change_oe;
  endproperty
  a_change_set: assert property (p_change_set) else $error("change line missed"); // R13

  property p_one_per_group;
    @(posedge ref_clk) disable iff (reset) !multi;
  endproperty
  a_one_per_group: assert property (p_one_per_group) else $error("two touched in group"); // R5

  property p_pos_range;
    @(posedge ref_clk) disable iff (reset)
      $changed(pos_r) |-> pos_r <= touch_pkg::max_code(res_r);
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("position above top code"); // R3

  property p_lock_hold;
    @(posedge ref_clk) disable iff (reset)
      scan_done && keep[1] |=> lock_v_r[1] && lock_id_r[1] == $past(lock_id_r[1]);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("dominant lock lost"); // R6

  property p_slider_together;
    @(posedge ref_clk) disable iff (reset)
      scan_done && slider_rep_nxt |=> slider_rep_r &&
        (status_r & 16'(9'h0FF >> (4'h8 - slen))) == (detect_r & 16'(9'h0FF >> (4'h8 - slen)));
  endproperty
  a_slider_together: assert property (p_slider_together) else $error("slider key dropped"); // R8

  property p_exempt_key;
    @(posedge ref_clk) disable iff (reset)
      scan_done && obj_grp[12] == 2'h0 |=> status_r[12] == $past(detect_r[12]);
  endproperty
  a_exempt_key: assert property (p_exempt_key) else $error("exempt key suppressed"); // R7

  sequence s_access;
    psel && penable && !pready;
  endsequence
  property p_apb_wait;
    @(posedge ref_clk) disable iff (reset) s_access |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer not one cycle");
endmodule // touch_status

// *** sim/electrode_matrix_model.sv ***
// Purpose: Behavioural electrode matrix, one result per key per scan
// Assumes: Keys visited in index order, then one end-of-scan pulse
// Notes:   Idle qualifiers toggle so stale values never pass as data
`timescale 1ns/1ps
module electrode_matrix_model (
  input  wire logic        ref_clk,
  output logic             acq_valid,
  output logic [3:0]       acq_key,
  output logic             acq_above,
  output logic [11:0]      acq_delta,
  output logic             scan_done
);
  logic [15:0] touch;
  logic [11:0] level [16];

  // Quiet outputs and an untouched panel at start
  initial begin
    acq_valid = 1'b0;
    acq_key   = 4'h0;
    acq_above = 1'b0;
    acq_delta = 12'h000;
    scan_done = 1'b0;
    touch     = 16'h0000;
    foreach (level[i]) level[i] = 12'h000;
  end

  // One scan: a result per key, then the end-of-scan pulse
  task automatic run_scan();
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      acq_valid <= 1'b1;
      acq_key   <= 4'(i);
      acq_above <= touch[i];
      acq_delta <= touch[i] ? level[i] : 12'(i);  // Small noise floor when idle
    end
    @(posedge ref_clk);
    acq_valid <= 1'b0;
    acq_key   <= ~acq_key;    // Stale qualifiers scrambled
    acq_delta <= ~acq_delta;
    scan_done <= 1'b1;
    @(posedge ref_clk);
    scan_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule // electrode_matrix_model

// *** sim/slider_position_key_suppression_test.sv ***
// Purpose: Self-checking bench for slider position and key suppression
// Assumes: Status settles within two cycles after scan_done
// Notes:   Slider key bits of STATUS are masked; the object bit and plain keys are judged
`timescale 1ns/1ps
module slider_position_key_suppression_test;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        change_n;
  logic        change_oe;
  logic        acq_valid;
  logic [3:0]  acq_key;
  logic        acq_above;
  logic [11:0] acq_delta;
  logic        scan_done;
  int          error_cnt  = 0;
  int          n_compared = 0;
  logic [31:0] rd;
  logic        err;
  int          k;
  logic [11:0] d;

  // 50 MHz core clock
  always #10 ref_clk = ~ref_clk;

  touch_status u_touch_status (.ref_clk(ref_clk), .reset(reset), .acq_valid(acq_valid),
    .acq_key(acq_key), .acq_above(acq_above), .acq_delta(acq_delta), .scan_done(scan_done),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .change_n(change_n),
    .change_oe(change_oe));

  electrode_matrix_model u_electrode_matrix_model (.ref_clk(ref_clk), .acq_valid(acq_valid),
    .acq_key(acq_key), .acq_above(acq_above), .acq_delta(acq_delta), .scan_done(scan_done));

  // Single exit point of the run
  task automatic print_verdict();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Word and flag comparisons, case equality so unknowns fail
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // APB transfer; waits on pready with a bounded count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Look mid-cycle: pready only moves at rising edges, so no race
    do begin
      @(negedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // These values stand unchanged at the next rising edge
    rd      = prdata;
    err     = pslverr;
    @(posedge ref_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: no pready", $time);
      print_verdict();
    end
  endtask

  // Panel stimulus helpers
  task automatic set_key(input int key, input logic t, input logic [11:0] lvl);
    u_electrode_matrix_model.touch[key] = t;
    u_electrode_matrix_model.level[key] = lvl;
  endtask

  task automatic scan(input int times);
    repeat (times) u_electrode_matrix_model.run_scan();
  endtask

  // Expected position for a centroid of num steps over den slider steps
  function automatic logic [31:0] pos_exp(input int num, input int den, input int res);
    return 32'(num * ((1 << res) - 1) / den);
  endfunction

  initial begin
    rd = $urandom(32'h701E);
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, touch_pkg::OFS_CTRL, 32'h0);
    check_word(rd, 32'h0000_0A80, "ctrl reset");
    apb(1'b0, touch_pkg::OFS_GROUP, 32'h0);
    check_word(rd, touch_pkg::GROUP_RST, "group reset");
    apb(1'b0, touch_pkg::OFS_RAW, 32'h0);
    check_word(rd, 32'h0, "raw reset");
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    check_bit(err, 1'b1, "unmapped refused");
    check_bit(change_n, 1'b1, "change idle");
    apb(1'b1, touch_pkg::OFS_GROUP, 32'h0050_0155);
    // Integrator with a limit of three successive acquisitions
    apb(1'b1, touch_pkg::OFS_CTRL, 32'h0000_0380);
    set_key(9, 1'b1, 12'($urandom_range(100, 3000)));
    scan(2);
    apb(1'b0, touch_pkg::OFS_RAW, 32'h0);
    check_word(rd, 32'h0, "raw before limit");
    scan(1);
    apb(1'b0, touch_pkg::OFS_RAW, 32'h0);
    check_word(rd, 32'h0000_0200, "raw at limit");
    check_bit(change_n, 1'b0, "change set");
    check_bit(change_oe, 1'b1, "change driven");
    apb(1'b0, touch_pkg::OFS_STATUS, 32'h0);
    check_word(rd, 32'h0000_0200, "exempt key");
    @(posedge ref_clk);
    check_bit(change_n, 1'b1, "change cleared");
    set_key(9, 1'b0, 12'h000);
    scan(1);
    set_key(9, 1'b1, 12'h300);
    scan(2);
    apb(1'b0, touch_pkg::OFS_RAW, 32'h0);
    check_word(rd, 32'h0, "counter restarted");
    set_key(9, 1'b0, 12'h000);
    // Group of keys 10 and 11 with random deltas, 12 and 13 exempt
    apb(1'b1, touch_pkg::OFS_CTRL, 32'h0000_0180);
    d = 12'($urandom_range(100, 1999));
    set_key(10, 1'b1, d);
    set_key(11, 1'b1, d + 12'($urandom_range(1, 1000)));
    set_key(12, 1'b1, 12'h0C8);
    set_key(13, 1'b1, 12'h0C8);
    scan(1);
    apb(1'b0, touch_pkg::OFS_RAW, 32'h0);
    check_word(rd, 32'h0000_3C00, "raw group");
    apb(1'b0, touch_pkg::OFS_STATUS, 32'h0);
    check_word(rd, 32'h0000_3800, "dominant");
    set_key(10, 1'b1, 12'hFA0);
    scan(1);
    apb(1'b0, touch_pkg::OFS_STATUS, 32'h0);
    check_word(rd, 32'h0000_3800, "lock held");
    set_key(11, 1'b0, 12'h000);
    scan(2);
    apb(1'b0, touch_pkg::OFS_STATUS, 32'h0);
    check_word(rd, 32'h0000_3400, "lock released");
    for (int i = 0; i < 16; i++) set_key(i, 1'b0, 12'h000);
    // Slider of four keys sharing group 1 with key 4
    apb(1'b1, touch_pkg::OFS_CTRL, 32'h0000_0184);
    set_key(4, 1'b1, 12'h032);
    scan(1);
    set_key(1, 1'b1, 12'h7D0);
    set_key(3, 1'b1, 12'h7D0);
    set_key(5, 1'b1, 12'h100);
    scan(1);
    apb(1'b0, touch_pkg::OFS_STATUS, 32'h0);
    check_word(rd & 32'h0001_FFF0, 32'h0000_0030, "key first");
    set_key(4, 1'b0, 12'h000);
    scan(2);
    apb(1'b0, touch_pkg::OFS_STATUS, 32'h0);
    check_word(rd & 32'h0001_FFF0, 32'h0001_0020, "slider object");
    apb(1'b0, touch_pkg::OFS_POSITION, 32'h0);
    check_word(rd, pos_exp(2, 3, 8), "two-key centroid");
    set_key(4, 1'b1, 12'hFA0);
    scan(1);
    apb(1'b0, touch_pkg::OFS_STATUS, 32'h0);
    check_word(rd & 32'h0001_FFF0, 32'h0001_0020, "slider first");
    set_key(4, 1'b0, 12'h000);
    // Resolutions 2, 4, 6 and 8 with one random slider key touched
    for (int r = 2; r <= 8; r += 2) begin
      k = $urandom_range(0, 3);
      for (int i = 0; i < 4; i++) set_key(i, 1'b0, 12'h000);
      set_key(k, 1'b1, 12'($urandom_range(200, 3000)));
      apb(1'b1, touch_pkg::OFS_CTRL, 32'h0000_0104 | 32'(r << 4));
      scan(1);
      apb(1'b0, touch_pkg::OFS_POSITION, 32'h0);
      check_word(rd, pos_exp(k, 3, r), "position");
    end
    // Shortest slider, far key lands exactly on the top code
    for (int i = 0; i < 4; i++) set_key(i, 1'b0, 12'h000);
    set_key(1, 1'b1, 12'h400);
    apb(1'b1, touch_pkg::OFS_CTRL, 32'h0000_0182);
    scan(1);
    apb(1'b0, touch_pkg::OFS_POSITION, 32'h0);
    check_word(rd, 32'h0000_00FF, "short slider");
    print_verdict();
  end
endmodule // slider_position_key_suppression_test
